/* hbp_pkg.sv */
/*
  hbp_pkg: shared constants and types of the host port block.
  Assumes: a single clock domain; register offsets are byte addresses on AXI4-Lite.
*/
package hbp_pkg;
  // bus and register file geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 5;
  localparam int SRC_W = 8;
  // queue geometry
  localparam int QUEUE_BYTES = 64;
  localparam int HALF_BYTES = 32;
  localparam int PTR_W = 6;
  localparam logic [PTR_W-1:0] RXLEN_MIN = 6'h02;
  localparam logic [PTR_W-1:0] RXLEN_MAX = 6'h20;
  localparam logic [PTR_W-1:0] RXLEN_RESET = 6'h20;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RXLEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FIFO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LANE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SRC = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h40;
  localparam int REG_STRIDE = 4;
  // field positions
  localparam int CTRL_VIS_BIT = 0;
  localparam int CTRL_OD_BIT = 1;
  localparam int CTRL_RXREL_BIT = 2;
  localparam int CTRL_TXSEND_BIT = 3;
  localparam int MODE_DS_BIT = 0;
  localparam int MODE_MUX_BIT = 1;
  localparam int MODE_WIDE_BIT = 2;
  localparam int LANE_A0_BIT = 0;
  localparam int LANE_BEN_BIT = 1;
  localparam int EV_RX_FULL_BIT = 0;
  localparam int EV_TX_DONE_BIT = 1;
  localparam int LO_BYTE = 8;
  localparam int HALFWORD = 16;
  // byte counts of one host access
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_WORD = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HBP_XFER_NONE,
    HBP_XFER_EVEN,
    HBP_XFER_ODD,
    HBP_XFER_WORD
  } hbp_xfer_t;

  typedef struct packed {
    hbp_xfer_t kind;
    logic [1:0] nbytes;
    logic hi_first;
  } hbp_lane_t;

  typedef struct packed {
    logic ds;
    logic mux;
    logic wide;
  } hbp_mode_t;
endpackage

/* hbp_lane_decode.sv */
/*
  hbp_lane_decode: maps byte enable and address bit zero onto data lanes.
  Assumes: mode is already registered; purely combinational.
*/
`timescale 1ns/10ps
module hbp_lane_decode import hbp_pkg::*; (
  // bus configuration
  input wire hbp_mode_t mode,
  // access qualifiers
  input wire logic addr_bit_zero,
  input wire logic byte_enable_n,
  // result
  output hbp_lane_t lane
);
  // narrow bus always moves one byte on the low lane
  always_comb begin
    lane.kind = HBP_XFER_NONE;
    if (!mode.wide) begin
      lane.kind = addr_bit_zero ? HBP_XFER_ODD : HBP_XFER_EVEN;
    end else begin
      unique case ({byte_enable_n, addr_bit_zero})
        2'b00: lane.kind = HBP_XFER_WORD; // see R2 see R3
        2'b01: lane.kind = HBP_XFER_ODD;
        2'b10: lane.kind = HBP_XFER_EVEN;
        2'b11: lane.kind = HBP_XFER_NONE;
      endcase
    end
    unique case (lane.kind)
      HBP_XFER_WORD: lane.nbytes = BYTES_WORD;
      HBP_XFER_NONE: lane.nbytes = BYTES_NONE;
      default: lane.nbytes = BYTES_ONE;
    endcase
    // data-strobe style puts the even byte high, the other style the odd byte
    lane.hi_first = mode.wide && (mode.ds ? (lane.kind != HBP_XFER_ODD)
                                          : (lane.kind == HBP_XFER_ODD)); // see R2 see R3
  end
endmodule // hbp_lane_decode

/* hbp_queue.sv */
/*
  hbp_queue: byte queue split in two halves, host owns one, line side the other.
  Assumes: host write and host read never in the same cycle; swap is a pulse.
*/
`timescale 1ns/10ps
module hbp_queue import hbp_pkg::*; #(
  parameter int DEPTH = QUEUE_BYTES,
  parameter int HALF = HALF_BYTES,
  parameter int PW = PTR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic [PW-1:0] limit,
  input wire logic swap,
  // host side
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_n,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // line side
  input wire logic line_wr,
  input wire logic [7:0] line_wdata,
  input wire logic line_rd,
  output logic line_ready,
  output logic line_valid,
  output logic [7:0] line_rdata,
  output logic line_full_ev,
  output logic line_empty_ev
);
  localparam int OW = $clog2(HALF);
  logic [7:0] mem [DEPTH];
  logic half;
  logic [PW-1:0] hptr, lptr, hlen, llen, hp1, bound, next_lptr, next_llen;
  logic h_ok0, h_ok1, l_wr, l_rd, next_half;

  // only the host half is ever touched by the host
  assign hp1 = hptr + PW'(1);
  assign bound = host_wr ? limit : hlen;
  assign h_ok0 = (host_wr || host_rd) && host_n != BYTES_NONE && hptr < bound; // see R5
  assign h_ok1 = (host_wr || host_rd) && host_n == BYTES_WORD && hp1 < bound;
  assign host_rdata = {(hp1 < hlen) ? mem[{half, hp1[OW-1:0]}] : 8'h00,
                       (hptr < hlen) ? mem[{half, hptr[OW-1:0]}] : 8'h00};
  assign l_wr = line_wr && lptr < limit;
  assign l_rd = line_rd && lptr < llen;
  assign next_half = swap ? ~half : half;
  assign next_lptr = swap ? '0 : lptr + PW'(l_wr || l_rd);
  assign next_llen = swap ? hptr : llen;

  // storage, line side writes the half the host cannot see
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (h_ok0 && host_wr) begin
        mem[{half, hptr[OW-1:0]}] <= host_wdata[7:0];
      end
      if (h_ok1 && host_wr) begin
        mem[{half, hp1[OW-1:0]}] <= host_wdata[15:8];
      end
      if (l_wr) begin
        mem[{~half, lptr[OW-1:0]}] <= line_wdata;
      end
    end
  end

  // pointers and line flags; flags look one cycle ahead so they never go stale
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      half <= 1'b0;
      hptr <= '0;
      lptr <= '0;
      hlen <= '0;
      llen <= '0;
      line_ready <= 1'b0;
      line_valid <= 1'b0;
      line_rdata <= 8'h00;
      line_full_ev <= 1'b0;
      line_empty_ev <= 1'b0;
    end else if (ce) begin
      half <= next_half;
      lptr <= next_lptr;
      llen <= next_llen;
      if (swap) begin
        hptr <= '0;
        hlen <= lptr;
      end else begin
        hptr <= hptr + PW'(h_ok0) + PW'(h_ok1); // see R6
      end
      line_ready <= next_lptr < limit;
      line_valid <= next_lptr < next_llen;
      line_rdata <= mem[{~next_half, next_lptr[OW-1:0]}];
      line_full_ev <= l_wr && lptr + PW'(1) == limit;
      line_empty_ev <= l_rd && lptr + PW'(1) == llen;
    end
  end
endmodule // hbp_queue

/* hbp_host_port.sv */
/*
  hbp_host_port: host port of the framer with byte/word queues and interrupt logic.
  Assumes: one clock, synchronous inputs, AXI4-Lite master with one access at a time.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
// Functional notes
// R1: two bus styles, 8 or 16 bits wide
// R2: strobe style lanes from byte enable, A0
// R3: data-strobe style lanes from lane select, A0
// R4: style and multiplexing from select and strobe
// R5: 64-byte queues, only one 32-byte half visible
// R6: byte and word queue accesses mix freely
// R7: word queue access only with wide strap
// R8: receive half length programmable 32 down to 2
// R9: one interrupt pin, open-drain or push-pull
// R10: source status registers clear on read
// R11: mask bit blocks interrupt and status bit
// R12: global register points at pending sources
// R13: host reads global first, then source
// R14: interrupt drops once all pending read away
// R15: status updates blocked only during reads
// R16: global holds one flag per source
// R17: visible mode shows masked bits, no interrupt
// R18: events during a read kept for later
`timescale 1ns/10ps
module hbp_host_port import hbp_pkg::*; (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // bus configuration straps
  input wire logic bus_style_select,
  input wire logic bus_width_strap,
  input wire logic host_latch_strobe,
  // event sources of the device
  input wire logic [NUM_SRC-1:0][SRC_W-1:0] src_event,
  // receive line side
  input wire logic rx_line_valid,
  input wire logic [7:0] rx_line_data,
  output logic rx_line_ready,
  // transmit line side
  output logic tx_line_valid,
  output logic [7:0] tx_line_data,
  input wire logic tx_line_take,
  // interrupt
  output logic irq,
  output logic irq_n_out,
  output logic irq_oe
);
  hbp_mode_t mode;
  hbp_lane_t lane;
  logic strobe_last, strobe_primed, strobe_seen;
  logic aw_held, w_held, wr_lo, wr_fire, wr_hit, rd_hit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, rd_mux;
  logic aw_ok, w_ok, ar_ok, rd_fifo, wr_fifo;
  logic masked_visible_ctrl, irq_pin_config;
  logic addr_bit_zero, byte_enable_n;
  logic [PTR_W-1:0] rx_len, len_req;
  logic rx_swap, tx_swap, rx_full_ev, tx_empty_ev;
  logic [15:0] fifo_wb, rx_raw, fifo_rd16;
  logic [NUM_SRC-1:0][SRC_W-1:0] source_status_regs, source_mask_regs, held_ev;
  logic [NUM_SRC-1:0][SRC_W-1:0] ev, gated_ev;
  logic [NUM_SRC-1:0] rd_src, wr_mask, pend_next, global_pointer_status;

  assign aw_ok = awvalid && awready;
  assign w_ok = wvalid && wready;
  assign ar_ok = arvalid && arready;
  assign wr_fire = aw_held && w_held && !bvalid;

  // bus style from the select strap; a moving latch strobe means multiplexed, in strobe style only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strobe_last <= 1'b0;
      strobe_primed <= 1'b0;
      strobe_seen <= 1'b0;
      mode <= '0;
    end else if (ce) begin
      strobe_last <= host_latch_strobe;
      strobe_primed <= 1'b1;
      if (strobe_primed && strobe_last != host_latch_strobe) begin
        strobe_seen <= 1'b1; // see R4
      end
      mode.ds <= bus_style_select; // see R1 see R4
      mode.mux <= strobe_seen && !bus_style_select; // see R4
      mode.wide <= bus_width_strap; // see R1 see R7
    end
  end

  // write channels, address and data taken in either order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lo <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (aw_ok) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (w_ok) begin
        wready <= 1'b0;
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_lo <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // ready only returns after the response, so one write at a time
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // write decode
  always_comb begin
    wr_hit = wr_addr inside {OFS_CTRL, OFS_MODE, OFS_RXLEN, OFS_GLOBAL, OFS_FIFO, OFS_LANE};
    for (int i = 0; i < NUM_SRC; i++) begin
      wr_mask[i] = wr_fire && wr_lo && wr_addr == ADDR_W'(OFS_SRC + REG_STRIDE * i);
      if (wr_addr == ADDR_W'(OFS_MASK + REG_STRIDE * i)
          || wr_addr == ADDR_W'(OFS_SRC + REG_STRIDE * i)) begin
        wr_hit = 1'b1;
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      wr_mask[i] = wr_fire && wr_lo && wr_addr == ADDR_W'(OFS_MASK + REG_STRIDE * i);
    end
  end

  // control, lane select, length and masks
  assign len_req = wr_data[PTR_W-1:0];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      masked_visible_ctrl <= 1'b0;
      irq_pin_config <= 1'b0;
      addr_bit_zero <= 1'b0;
      byte_enable_n <= 1'b0;
      rx_len <= RXLEN_RESET; // see R8
      source_mask_regs <= '0;
    end else if (ce && wr_fire && wr_lo) begin
      if (wr_addr == OFS_CTRL) begin
        masked_visible_ctrl <= wr_data[CTRL_VIS_BIT];
        irq_pin_config <= wr_data[CTRL_OD_BIT]; // see R9
      end
      if (wr_addr == OFS_LANE) begin
        addr_bit_zero <= wr_data[LANE_A0_BIT];
        byte_enable_n <= wr_data[LANE_BEN_BIT];
      end
      // out-of-range lengths are clamped rather than refused
      if (wr_addr == OFS_RXLEN) begin
        rx_len <= (len_req < RXLEN_MIN) ? RXLEN_MIN :
                  (len_req > RXLEN_MAX) ? RXLEN_MAX : len_req; // see R8
      end
      for (int i = 0; i < NUM_SRC; i++) begin
        if (wr_mask[i]) begin
          source_mask_regs[i] <= wr_data[SRC_W-1:0]; // see R11
        end
      end
    end
  end

  // commands and queue access strobes
  assign rx_swap = wr_fire && wr_lo && wr_addr == OFS_CTRL && wr_data[CTRL_RXREL_BIT];
  assign tx_swap = wr_fire && wr_lo && wr_addr == OFS_CTRL && wr_data[CTRL_TXSEND_BIT];
  assign wr_fifo = wr_fire && wr_lo && wr_addr == OFS_FIFO;
  assign rd_fifo = ar_ok && araddr == OFS_FIFO;

  hbp_lane_decode u_lane (
    .mode(mode),
    .addr_bit_zero(addr_bit_zero),
    .byte_enable_n(byte_enable_n),
    .lane(lane)
  );

  // first queue byte sits on the lane the style dictates
  assign fifo_wb = lane.hi_first ? {wr_data[LO_BYTE-1:0], wr_data[HALFWORD-1:LO_BYTE]}
                                 : wr_data[HALFWORD-1:0]; // see R2 see R3
  always_comb begin
    unique case (lane.nbytes)
      BYTES_WORD: fifo_rd16 = lane.hi_first ? {rx_raw[7:0], rx_raw[15:8]} : rx_raw;
      BYTES_ONE: fifo_rd16 = lane.hi_first ? {rx_raw[7:0], 8'h00} : {8'h00, rx_raw[7:0]};
      default: fifo_rd16 = 16'h0000;
    endcase
  end

  hbp_queue u_rx_queue (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .limit(rx_len), .swap(rx_swap),
    .host_wr(1'b0), .host_rd(rd_fifo), .host_n(lane.nbytes), // see R6 see R7
    .host_wdata(16'h0000), .host_rdata(rx_raw),
    .line_wr(rx_line_valid && rx_line_ready), .line_wdata(rx_line_data),
    .line_rd(1'b0), .line_ready(rx_line_ready), .line_valid(),
    .line_rdata(), .line_full_ev(rx_full_ev), .line_empty_ev()
  );

  hbp_queue u_tx_queue (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .limit(RXLEN_MAX), .swap(tx_swap),
    .host_wr(wr_fifo), .host_rd(1'b0), .host_n(lane.nbytes), // see R6 see R7
    .host_wdata(fifo_wb), .host_rdata(),
    .line_wr(1'b0), .line_wdata(8'h00),
    .line_rd(tx_line_take && tx_line_valid), .line_ready(),
    .line_valid(tx_line_valid), .line_rdata(tx_line_data),
    .line_full_ev(), .line_empty_ev(tx_empty_ev)
  );

  // read decode
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    rd_src = '0;
    unique case (araddr)
      OFS_CTRL: begin
        rd_mux[CTRL_VIS_BIT] = masked_visible_ctrl;
        rd_mux[CTRL_OD_BIT] = irq_pin_config;
      end
      OFS_MODE: begin
        rd_mux[MODE_DS_BIT] = mode.ds;
        rd_mux[MODE_MUX_BIT] = mode.mux;
        rd_mux[MODE_WIDE_BIT] = mode.wide;
      end
      OFS_RXLEN: rd_mux[PTR_W-1:0] = rx_len;
      OFS_GLOBAL: rd_mux[NUM_SRC-1:0] = global_pointer_status; // see R12
      OFS_FIFO: rd_mux[HALFWORD-1:0] = fifo_rd16;
      OFS_LANE: begin
        rd_mux[LANE_A0_BIT] = addr_bit_zero;
        rd_mux[LANE_BEN_BIT] = byte_enable_n;
      end
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
          if (araddr == ADDR_W'(OFS_SRC + REG_STRIDE * i)) begin
            rd_mux[SRC_W-1:0] = source_status_regs[i];
            rd_src[i] = ar_ok;
            rd_hit = 1'b1;
          end
          if (araddr == ADDR_W'(OFS_MASK + REG_STRIDE * i)) begin
            rd_mux[SRC_W-1:0] = source_mask_regs[i];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // read channels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_ok) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // events, masked ones dropped unless visible mode
  always_comb begin
    ev = src_event;
    ev[0][EV_RX_FULL_BIT] = src_event[0][EV_RX_FULL_BIT] | rx_full_ev;
    ev[0][EV_TX_DONE_BIT] = src_event[0][EV_TX_DONE_BIT] | tx_empty_ev;
    for (int i = 0; i < NUM_SRC; i++) begin
      gated_ev[i] = masked_visible_ctrl ? ev[i] : ev[i] & ~source_mask_regs[i]; // see R11 see R17
      pend_next[i] = |(source_status_regs[i] & ~source_mask_regs[i]); // see R16 see R17
    end
  end

  // sticky status; any read parks new events, merged once the read is over
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      source_status_regs <= '0;
      held_ev <= '0;
    end else if (ce) begin
      if (ar_ok) begin
        held_ev <= held_ev | gated_ev; // see R15 see R18
        for (int i = 0; i < NUM_SRC; i++) begin
          if (rd_src[i]) begin
            source_status_regs[i] <= '0; // see R10 see R17
          end
        end
      end else begin
        source_status_regs <= source_status_regs | held_ev | gated_ev; // see R15
        held_ev <= '0;
      end
    end
  end

  // global pointer and pin; frozen during reads like the status registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      global_pointer_status <= '0;
      irq <= 1'b0;
      irq_n_out <= 1'b1;
      irq_oe <= 1'b0;
    end else if (ce && !ar_ok) begin
      global_pointer_status <= pend_next; // see R12 see R13 see R16
      irq <= |pend_next; // see R9 see R14
      irq_n_out <= irq_pin_config ? 1'b0 : ~(|pend_next); // see R9
      irq_oe <= irq_pin_config ? |pend_next : 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_word_needs_wide: assert property (lane.kind == HBP_XFER_WORD |-> mode.wide) // see R7
    else $error("word access without wide strap");
  chk_rw_odd_lane: assert property (mode.wide && !mode.ds && !byte_enable_n && addr_bit_zero
      |-> lane.hi_first && lane.nbytes == BYTES_ONE) // see R2
    else $error("odd byte not on high lane");
  chk_ds_odd_lane: assert property (mode.wide && mode.ds && !byte_enable_n && addr_bit_zero
      |-> !lane.hi_first && lane.nbytes == BYTES_ONE) // see R3
    else $error("odd byte not on low lane");
  chk_mux_style: assert property (mode.mux |-> !mode.ds && strobe_seen) // see R4
    else $error("multiplexed with data strobe");
  chk_rxlen_range: assert property (rx_len >= RXLEN_MIN && rx_len <= RXLEN_MAX) // see R8
    else $error("receive length out of range");
  chk_clear_on_read: assert property (ce && rd_src[0] |=> source_status_regs[0] == '0) // see R10
    else $error("status not cleared by read");
  chk_read_freeze: assert property (ce && ar_ok |=> $stable(global_pointer_status)) // see R15
    else $error("global changed during read");
  chk_global_ptr: assert property (ce && !ar_ok |=> global_pointer_status
      == $past(pend_next)) // see R12 see R16
    else $error("global pointer wrong");
  chk_event_kept: assert property (ce && rd_src[1] && gated_ev[1][0] ##1 (ce && !ar_ok)
      |=> source_status_regs[1][0]) // see R18
    else $error("event lost during read");
  chk_irq_global: assert property (irq == (|global_pointer_status)) // see R14
    else $error("irq disagrees with global");
  chk_od_pin: assert property (irq_pin_config && ce && !ar_ok |=> !irq_n_out
      && irq_oe == irq) // see R9
    else $error("open drain pin wrong");
  chk_masked_quiet: assert property (ce && !ar_ok && source_mask_regs[2] == '1
      |=> !global_pointer_status[2]) // see R11
    else $error("masked source in global");

  cov_word_write: cover property (wr_fifo && lane.kind == HBP_XFER_WORD);
  cov_rx_swap: cover property (rx_full_ev ##[1:200] rx_swap);
  cov_irq_rise: cover property (!irq ##1 irq);
  cov_read_event: cover property (rd_src[0] && |gated_ev[0]);
endmodule // hbp_host_port

/* hbp_host_model.sv */
/* hbp_host_model: host cpu issuing axi4-lite accesses, one at a time.
   Assumes: tasks are entered just after a rising edge of mclk. */
`timescale 1ns/10ps
module hbp_host_model import hbp_pkg::*; (
  // clock
  input wire logic mclk,
  // write channels
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // taken payload is inverted so a stale value never passes as valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  // read waits for rvalid, however long the answer takes
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rready && rvalid) begin
        d = rdata;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
  endtask
  // global pointer first, then the source it names
  task automatic service(output logic [4:0] g, output logic [7:0] s);
    logic [31:0] d;
    int i;
    rd(OFS_GLOBAL, d);
    g = d[4:0];
    i = 0;
    while (i < 4 && !g[i]) i++;
    rd(OFS_SRC + 8'(REG_STRIDE * i), d);
    s = d[7:0];
  endtask
endmodule // hbp_host_model

/* hbp_host_port_test.sv */
/* hbp_host_port_test: self-checking bench of the host port.
   Assumes: host model drives axi; bench drives straps, events, line side. */
`timescale 1ns/10ps
module hbp_host_port_test;
  import hbp_pkg::*;
  logic mclk = 0, rst_n = 0, ce = 1;
  logic [7:0] awaddr, araddr, rx_line_data = 0, tx_line_data, s;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_line_ready, tx_line_valid;
  logic bus_style_select = 0, bus_width_strap = 1, host_latch_strobe = 0;
  logic rx_line_valid = 0, tx_line_take = 0, irq, irq_n_out, irq_oe;
  logic [NUM_SRC-1:0][SRC_W-1:0] src_event = '0;
  logic [4:0] g;
  int err_count = 0, compares = 0, cycles = 0;
  always #2 mclk = ~mclk;
  hbp_host_port dut_u (.mclk, .rst_n, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .bus_style_select, .bus_width_strap, .host_latch_strobe,
    .src_event, .rx_line_valid, .rx_line_data, .rx_line_ready, .tx_line_valid,
    .tx_line_data, .tx_line_take, .irq, .irq_n_out, .irq_oe);
  hbp_host_model host_u (.mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle event on source i bit b, then let irq settle
  task automatic pulse(input int i, input int b);
    src_event[i][b] <= 1'b1;
    @(posedge mclk);
    src_event <= '0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_irq;
    pulse(2, 3);
    chk(32'({irq, irq_n_out, irq_oe}), 32'h5);
    host_u.service(g, s);
    chk(32'(g), 32'h04);
    chk(32'(s), 32'h08);
    repeat (2) @(posedge mclk);
    chk(32'({irq, irq_n_out, irq_oe}), 32'h3);
    host_u.rd(OFS_GLOBAL, d);
    chk(d, 32'h0);
    // open-drain pin; event held high across a read of its own register
    host_u.wr(OFS_CTRL, 32'h02);
    src_event[1][0] <= 1'b1;
    host_u.rd(OFS_SRC + 8'h04, d);
    src_event <= '0;
    chk(d, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'({irq, irq_n_out, irq_oe}), 32'h5);
    host_u.rd(OFS_SRC + 8'h04, d);
    chk(d, 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'({irq, irq_n_out, irq_oe}), 32'h0);
    host_u.wr(OFS_CTRL, 32'h0);
    $display("irq test done");
  endtask
  task automatic t_mask;
    host_u.wr(OFS_MASK + 8'h08, 32'hff);
    pulse(2, 3);
    chk(32'(irq), 32'h0);
    host_u.rd(OFS_SRC + 8'h08, d);
    chk(d, 32'h0);
    host_u.wr(OFS_CTRL, 32'h01);
    pulse(2, 3);
    host_u.rd(OFS_GLOBAL, d);
    chk(d | 32'(irq), 32'h0);
    host_u.rd(OFS_SRC + 8'h08, d);
    chk(d, 32'h08);
    host_u.wr(OFS_CTRL, 32'h0);
    host_u.wr(OFS_MASK + 8'h08, 32'h0);
    $display("mask test done");
  endtask
  task automatic t_cfg;
    host_u.rd(OFS_RXLEN, d);
    chk(d, 32'h20);
    host_u.rd(8'hfc, d);
    chk(d, 32'h0);
    chk(32'(rresp), 32'(RESP_SLVERR));
    host_u.wr(8'hfc, 32'h0);
    chk(32'(bresp), 32'(RESP_SLVERR));
    host_u.wr(OFS_RXLEN, 32'h01);
    host_u.rd(OFS_RXLEN, d);
    chk(d, 32'h02);
    // odd lane selected while in data-strobe style
    host_u.wr(OFS_LANE, 32'h1);
    bus_style_select <= 1'b1;
    // mode is registered: one edge before it shows
    @(posedge mclk);
    host_u.rd(OFS_MODE, d);
    chk(d, 32'h5);
    bus_style_select <= 1'b0;
    host_latch_strobe <= 1'b1;
    // strobe edge seen first, multiplexed flag one edge later
    repeat (2) @(posedge mclk);
    host_u.rd(OFS_MODE, d);
    chk(d, 32'h6);
    $display("config test done");
  endtask
  // two line bytes fill a 2-byte half; host then reads even and odd byte
  task automatic t_rx;
    for (int i = 1; i <= 2; i++) begin
      rx_line_data <= 8'(i * 17);
      rx_line_valid <= 1'b1;
      do @(posedge mclk); while (!rx_line_ready);
    end
    rx_line_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'({rx_line_ready, irq}), 32'h1);
    host_u.wr(OFS_CTRL, 32'h04);
    host_u.wr(OFS_LANE, 32'h2);
    host_u.rd(OFS_FIFO, d);
    chk(32'(d[15:0]), 32'h0011);
    host_u.wr(OFS_LANE, 32'h1);
    host_u.rd(OFS_FIFO, d);
    chk(32'(d[15:0]), 32'h2200);
    host_u.service(g, s);
    chk(32'({g[0], s[0], rx_line_ready}), 32'h7);
    $display("rx test done");
  endtask
  task automatic t_tx;
    host_u.wr(OFS_LANE, 32'h0);
    host_u.wr(OFS_FIFO, 32'hbbaa);
    host_u.wr(OFS_CTRL, 32'h08);
    @(posedge mclk);
    chk(32'({tx_line_valid, tx_line_data}), 32'h1aa);
    tx_line_take <= 1'b1;
    @(posedge mclk);
    tx_line_take <= 1'b0;
    @(posedge mclk);
    chk(32'({tx_line_valid, tx_line_data}), 32'h1bb);
    // last byte taken: half drained, event raises the interrupt
    tx_line_take <= 1'b1;
    @(posedge mclk);
    tx_line_take <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'({tx_line_valid, irq}), 32'h1);
    host_u.rd(OFS_SRC, d);
    chk(d, 32'h2);
    $display("tx test done");
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_cfg();
    t_irq();
    t_mask();
    t_rx();
    t_tx();
    test_done();
  end
endmodule // hbp_host_port_test
